// ---- logic/vle_pkg.sv ----
/*
  Constants for the virtual interrupt entry block: register offsets,
  entry field layout, control bit positions and reset values.
  Assumes a 12-bit APB byte address with 32-bit data.
*/
`default_nettype none
package vle_pkg;
  localparam int MAX_ENTRIES = 64;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] BPR_OFS = 12'h004;
  localparam logic [11:0] ABPR_OFS = 12'h008;
  localparam logic [11:0] TYPE_OFS = 12'h00C;
  localparam logic [11:0] ACK_OFS = 12'h010;
  localparam logic [11:0] EOI_OFS = 12'h014;
  localparam logic [11:0] AEOI_OFS = 12'h018;
  localparam logic [11:0] DIR_OFS = 12'h01C;
  localparam logic [3:0] ENTRY_PAGE = 4'h1;
  localparam int HW_BIT = 31;
  localparam int GRP_BIT = 30;
  localparam int ACTIVE_BIT = 29;
  localparam int PENDING_BIT = 28;
  localparam int PRIO_LSB = 23;
  localparam int EOI_BIT = 19;
  localparam int PHYS_LSB = 10;
  localparam int CPU_LSB = 10;
  // State bits 29:28 are a defined field; only 22:20 are reserved
  localparam logic [31:0] ENTRY_MASK = 32'hFF8F_FFFF;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
  localparam logic [9:0] SPURIOUS_ID = 10'h3FF;
  localparam logic [9:0] SGI_LIMIT = 10'h010;
  localparam int GRP0_EN_BIT = 0;
  localparam int GROUP_ONE_FLAG_EN_BIT = 1;
  localparam int FIQ_SEL_BIT = 3;
  localparam int CBPR_BIT = 4;
  localparam int SPLIT_EOI_BIT = 9;
  localparam logic [31:0] CTRL_MASK = 32'h0000_021B;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] BPR_RESET = 3'h2;
  localparam logic [2:0] ABPR_RESET = 3'h3;
  localparam logic [2:0] BPR_DROP_BASE = 3'h2;
  localparam logic [2:0] ABPR_DROP_BASE = 3'h3;
endpackage
`default_nettype wire

// ---- logic/vle_entry_ctrl.sv ----
/*
  List of virtual interrupt entries with the virtual CPU interface logic
  that selects, acknowledges, ends and deactivates them, all behind APB.
  Assumes a single clock and that hypervisor and guest share the APB port;
  the distributor accepts a deactivate pulse in any cycle.
*/
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Up to 64 entries, count minus one in type register
// - Unbuilt entries read zero, ignore writes
// - Undefined entry bits read zero
// - Software entries never notify the distributor
// - Hardware entries forward deactivate with physical ID
// - Split select picks end or deactivate trigger
// - Group 0 routed IRQ or FIQ by select
// - Group 0 signalled only when enabled
// - Group 1 always IRQ, only when enabled
// - Common select picks binary point register
// - Two-bit state updated through interrupt life
// - Five-bit priority, reserved bits zero
// - End-of-interrupt maintenance request and requester number
// - Virtual ID returned on acknowledge
module vle_entry_ctrl import vle_pkg::*; #(
  parameter int NUM_ENTRIES = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic virq,
  output logic vfiq,
  output logic dist_deact_valid,
  output logic [9:0] dist_deact_id,
  output logic eoi_maint_req
);
  localparam int IDX_W = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1;

  logic [31:0] entry_reg [NUM_ENTRIES];
  logic [31:0] entry_next [NUM_ENTRIES];
  logic [NUM_ENTRIES-1:0] dropped_reg;
  logic [NUM_ENTRIES-1:0] dropped_next;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [2:0] bpr_reg;
  logic [2:0] bpr_next;
  logic [2:0] abpr_reg;
  logic [2:0] abpr_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic err_reg;
  logic err_next;
  logic virq_reg;
  logic virq_next;
  logic vfiq_reg;
  logic vfiq_next;
  logic deact_reg;
  logic deact_next;
  logic [9:0] deact_id_reg;
  logic [9:0] deact_id_next;
  logic maint_reg;
  logic maint_next;

  logic setup;
  logic access;
  logic entry_hit;
  logic [5:0] entry_slot;
  logic found;
  logic [IDX_W-1:0] best_idx;
  logic [4:0] best_prio;
  logic [5:0] run_prio;
  logic best_group_one_flag;
  logic [2:0] drop;
  logic [4:0] prio_mask;
  logic preempt;
  logic eoi_hit;
  logic [IDX_W-1:0] eoi_idx;
  logic dir_hit;
  logic [IDX_W-1:0] dir_idx;
  logic [31:0] ack_word;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign entry_hit = (paddr[11:8] == ENTRY_PAGE);
  assign entry_slot = paddr[7:2];

  // Candidate selection and running priority; lowest index wins a tie
  always_comb begin
    found = 1'b0;
    best_idx = '0;
    best_prio = 5'h1F;
    run_prio = 6'h20;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (entry_reg[i][ACTIVE_BIT] && !dropped_reg[i] &&
          ({1'b0, entry_reg[i][PRIO_LSB +: 5]} < run_prio)) begin
        run_prio = {1'b0, entry_reg[i][PRIO_LSB +: 5]};
      end
    end
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (entry_reg[i][PENDING_BIT] && !entry_reg[i][ACTIVE_BIT] &&
          (entry_reg[i][GRP_BIT] ? ctrl_reg[GROUP_ONE_FLAG_EN_BIT] : ctrl_reg[GRP0_EN_BIT]) &&
          (!found || (entry_reg[i][PRIO_LSB +: 5] < best_prio))) begin
        found = 1'b1;
        best_idx = IDX_W'(i);
        best_prio = entry_reg[i][PRIO_LSB +: 5];
      end
    end
  end

  // Group priority bits only; the aliased point sits one step finer
  always_comb begin
    best_group_one_flag = entry_reg[best_idx][GRP_BIT];
    drop = 3'h0;
    if (best_group_one_flag && !ctrl_reg[CBPR_BIT]) begin
      if (abpr_reg > ABPR_DROP_BASE) begin
        drop = abpr_reg - ABPR_DROP_BASE;
      end
    end else if (bpr_reg > BPR_DROP_BASE) begin
      drop = bpr_reg - BPR_DROP_BASE;
    end
    prio_mask = 5'h1F << drop;
    preempt = found && (run_prio[5] ||
              ((best_prio & prio_mask) < (run_prio[4:0] & prio_mask)));
  end

  // Entry lookup for end and deactivate writes by virtual ID
  always_comb begin
    eoi_hit = 1'b0;
    eoi_idx = '0;
    dir_hit = 1'b0;
    dir_idx = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (entry_reg[i][ACTIVE_BIT] && (entry_reg[i][9:0] == pwdata[9:0])) begin
        dir_hit = 1'b1;
        dir_idx = IDX_W'(i);
        if (!dropped_reg[i]) begin
          eoi_hit = 1'b1;
          eoi_idx = IDX_W'(i);
        end
      end
    end
  end

  // Acknowledge word: requester number only for software SGIs
  always_comb begin
    ack_word = {22'h0, SPURIOUS_ID};
    if (found) begin
      ack_word = {22'h0, entry_reg[best_idx][9:0]};
      if (!entry_reg[best_idx][HW_BIT] && (entry_reg[best_idx][9:0] < SGI_LIMIT)) begin
        ack_word[CPU_LSB +: 3] = entry_reg[best_idx][CPU_LSB +: 3];
      end
    end
  end

  // Read data and error are prepared in the setup cycle, so a zero-wait
  // access phase still returns flip-flop data
  always_comb begin
    rd_next = rd_reg;
    err_next = err_reg;
    if (setup) begin
      rd_next = 32'h0000_0000;
      err_next = 1'b0;
      if (entry_hit) begin
        if (int'(entry_slot) < NUM_ENTRIES) begin
          rd_next = entry_reg[entry_slot[IDX_W-1:0]] & ENTRY_MASK;
        end
      end else begin
        unique case (paddr)
          CTRL_OFS: rd_next = ctrl_reg & CTRL_MASK;
          BPR_OFS: rd_next = {29'h0, bpr_reg};
          ABPR_OFS: rd_next = {29'h0, abpr_reg};
          TYPE_OFS: rd_next = {26'h0, 6'(NUM_ENTRIES - 1)};
          ACK_OFS: rd_next = pwrite ? 32'h0000_0000 : ack_word;
          EOI_OFS, AEOI_OFS, DIR_OFS: rd_next = 32'h0000_0000;
          default: err_next = 1'b1;
        endcase
      end
    end
  end

  // Life-cycle updates; APB carries one request per cycle, so a software
  // entry write never meets a hardware update in the same cycle
  always_comb begin
    entry_next = entry_reg;
    dropped_next = dropped_reg;
    ctrl_next = ctrl_reg;
    bpr_next = bpr_reg;
    abpr_next = abpr_reg;
    deact_next = 1'b0;
    deact_id_next = deact_id_reg;
    if (access && pwrite && entry_hit) begin
      if (int'(entry_slot) < NUM_ENTRIES) begin
        entry_next[entry_slot[IDX_W-1:0]] = pwdata & ENTRY_MASK;
        dropped_next[entry_slot[IDX_W-1:0]] = 1'b0;
      end
    end else if (access && pwrite) begin
      unique case (paddr)
        CTRL_OFS: ctrl_next = pwdata & CTRL_MASK;
        BPR_OFS: bpr_next = pwdata[2:0];
        ABPR_OFS: abpr_next = pwdata[2:0];
        EOI_OFS, AEOI_OFS: begin
          if (eoi_hit) begin
            if (!ctrl_reg[SPLIT_EOI_BIT]) begin
              entry_next[eoi_idx][ACTIVE_BIT] = 1'b0;
              if (entry_reg[eoi_idx][HW_BIT]) begin
                deact_next = 1'b1;
                deact_id_next = entry_reg[eoi_idx][PHYS_LSB +: 10];
              end
            end else begin
              dropped_next[eoi_idx] = 1'b1;
            end
          end
        end
        DIR_OFS: begin
          if (dir_hit && ctrl_reg[SPLIT_EOI_BIT]) begin
            entry_next[dir_idx][ACTIVE_BIT] = 1'b0;
            dropped_next[dir_idx] = 1'b0;
            if (entry_reg[dir_idx][HW_BIT]) begin
              deact_next = 1'b1;
              deact_id_next = entry_reg[dir_idx][PHYS_LSB +: 10];
            end
          end
        end
        default: begin
        end
      endcase
    end else if (access && !pwrite && !entry_hit && (paddr == ACK_OFS) && found) begin
      entry_next[best_idx][PENDING_BIT] = 1'b0;
      entry_next[best_idx][ACTIVE_BIT] = 1'b1;
    end
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (!entry_next[i][ACTIVE_BIT]) begin
        dropped_next[i] = 1'b0;
      end
    end
  end

  // Outputs follow the registered state one cycle later
  always_comb begin
    virq_next = preempt && (best_group_one_flag || !ctrl_reg[FIQ_SEL_BIT]);
    vfiq_next = preempt && !best_group_one_flag && ctrl_reg[FIQ_SEL_BIT];
    maint_next = 1'b0;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (!entry_reg[i][ACTIVE_BIT] && !entry_reg[i][PENDING_BIT] &&
          !entry_reg[i][HW_BIT] && entry_reg[i][EOI_BIT]) begin
        maint_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        entry_reg[i] <= ENTRY_RESET;
      end
      dropped_reg <= '0;
      ctrl_reg <= CTRL_RESET;
      bpr_reg <= BPR_RESET;
      abpr_reg <= ABPR_RESET;
      rd_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      virq_reg <= 1'b0;
      vfiq_reg <= 1'b0;
      deact_reg <= 1'b0;
      deact_id_reg <= 10'h000;
      maint_reg <= 1'b0;
    end else begin
      entry_reg <= entry_next;
      dropped_reg <= dropped_next;
      ctrl_reg <= ctrl_next;
      bpr_reg <= bpr_next;
      abpr_reg <= abpr_next;
      rd_reg <= rd_next;
      err_reg <= err_next;
      virq_reg <= virq_next;
      vfiq_reg <= vfiq_next;
      deact_reg <= deact_next;
      deact_id_reg <= deact_id_next;
      maint_reg <= maint_next;
    end
  end

  assign prdata = rd_reg;
  assign pready = 1'b1;
  assign pslverr = err_reg && access;
  assign virq = virq_reg;
  assign vfiq = vfiq_reg;
  assign dist_deact_valid = deact_reg;
  assign dist_deact_id = deact_id_reg;
  assign eoi_maint_req = maint_reg;
endmodule // vle_entry_ctrl
`default_nettype wire

// ---- sim/vle_entry_monitor.sv ----
/* Port checker for vle_entry_ctrl.
   Bound from the bench top; one clock, synchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module vle_entry_monitor import vle_pkg::*; #(
  parameter int NUM_ENTRIES = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic virq,
  input wire logic vfiq,
  input wire logic dist_deact_valid,
  input wire logic [9:0] dist_deact_id,
  input wire logic eoi_maint_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_next;
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  wire logic page = paddr[11:8] == ENTRY_PAGE;
  wire logic wr_end = acc && pwrite && (paddr == EOI_OFS || paddr == AEOI_OFS || paddr == DIR_OFS);
  always_comb begin
    ctrl_next = ctrl_q;
    if (acc && pwrite && paddr == CTRL_OFS) ctrl_next = pwdata & CTRL_MASK;
  end
  // Shadow of the control word, so signalling can be tied to its enables
  always_ff @(posedge clock) ctrl_q <= reset ? CTRL_RESET : ctrl_next;
  wire logic fiq_ok = ctrl_q[GRP0_EN_BIT] && ctrl_q[FIQ_SEL_BIT];
  sequence eoi_wr;
    acc && pwrite && (paddr == EOI_OFS || paddr == AEOI_OFS);
  endsequence
  sequence dir_wr;
    acc && pwrite && paddr == DIR_OFS;
  endsequence
  type_read_a: assert property (rd && paddr == TYPE_OFS |-> prdata == 32'(NUM_ENTRIES - 1))
    else $error("type count wrong");
  spare_zero_a: assert property (rd && page && paddr[7:2] >= NUM_ENTRIES |-> prdata == 32'h0)
    else $error("unbuilt entry not zero");
  no_err_a: assert property (acc && page |-> !pslverr)
    else $error("entry access errored");
  reserved_bits_a: assert property (rd && page |-> (prdata & ~ENTRY_MASK) == 32'h0)
    else $error("undefined entry bits set");
  pulse_one_a: assert property (dist_deact_valid |=> !dist_deact_valid)
    else $error("deactivate pulse too long");
  deact_cause_a: assert property (dist_deact_valid |-> $past(wr_end))
    else $error("deactivate without end write");
  id_hold_a: assert property ($changed(dist_deact_id) |-> dist_deact_valid)
    else $error("deactivate id moved alone");
  split_eoi_a: assert property (eoi_wr ##0 ctrl_q[SPLIT_EOI_BIT] |=> !dist_deact_valid)
    else $error("end write deactivated in split mode");
  split_dir_a: assert property (dir_wr ##0 !ctrl_q[SPLIT_EOI_BIT] |=> !dist_deact_valid)
    else $error("deactivate write acted without split");
  fiq_enable_a: assert property (vfiq |-> fiq_ok || $past(fiq_ok) || $past(fiq_ok, 2))
    else $error("fast line without its enables");
endmodule // vle_entry_monitor
`default_nettype wire

// ---- sim/vle_dist_model.sv ----
/* Distributor side model: logs deactivate requests.
   Accepts a request in any cycle, as the block assumes. */
`timescale 1ns/100ps
`default_nettype none
module vle_dist_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [9:0] req_id,
  output int req_count,
  output logic [9:0] last_id
);
  always @(posedge clock) begin
    if (reset) begin
      req_count <= 0;
      last_id <= 10'h000;
    end else if (req_valid) begin
      req_count <= req_count + 1;
      last_id <= req_id;
    end
  end
endmodule // vle_dist_model
`default_nettype wire

// ---- sim/test_virtual_interrupt_list_entry.sv ----
/* Bench for vle_entry_ctrl: APB master, distributor model, checker bind.
   Assumes registered interrupt outputs that settle within three cycles. */
`timescale 1ns/100ps
`default_nettype none
module test_virtual_interrupt_list_entry import vle_pkg::*;;
  localparam int N = 4;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, e;
  logic pready, pslverr, virq, vfiq, dv, maint;
  logic [9:0] did, last_id, ph;
  int req_count, n_errors = 0, check_count = 0, cyc = 0;
  always #10 clock = ~clock;
  vle_entry_ctrl #(.NUM_ENTRIES(N)) dut_u (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .virq(virq), .vfiq(vfiq), .dist_deact_valid(dv),
    .dist_deact_id(did), .eoi_maint_req(maint));
  vle_dist_model dist_u (.clock(clock), .reset(reset), .req_valid(dv), .req_id(did),
    .req_count(req_count), .last_id(last_id));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  function automatic logic [31:0] entry(logic hw, logic g1, logic [4:0] pr, logic [9:0] mid,
      logic [9:0] vid);
    return {hw, g1, 2'h1, pr, 3'h0, mid, vid};
  endfunction
  function automatic logic [31:0] ack_id(logic [31:0] x);
    return (!x[31] && x[9:0] < 10'h010) ? {19'h0, x[12:0]} : {22'h0, x[9:0]};
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    e = $urandom(72);
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    apb(1'h0, TYPE_OFS, 32'h0);
    check(rd, N - 1);
    apb(1'h0, 12'h020, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test registers done");
    for (int i = 0; i <= N; i++) begin
      e = $urandom();
      apb(1'h1, 12'h100 + 12'(i * 4), e);
      apb(1'h0, 12'h100 + 12'(i * 4), 32'h0);
      check(rd, i < N ? e & ENTRY_MASK : 32'h0);
      apb(1'h1, 12'h100 + 12'(i * 4), 32'h0);
    end
    $display("test fields done");
    ph = 10'($urandom());
    e = entry(1'h1, 1'h0, 5'h04, ph, 10'h005);
    apb(1'h1, CTRL_OFS, 32'h9);
    apb(1'h1, 12'h100, e);
    settle();
    check(32'({virq, vfiq}), 32'h1);
    apb(1'h1, CTRL_OFS, 32'h8);
    settle();
    check(32'({virq, vfiq}), 32'h0);
    apb(1'h1, CTRL_OFS, 32'h1);
    settle();
    check(32'({virq, vfiq}), 32'h2);
    apb(1'h0, ACK_OFS, 32'h0);
    check(rd, ack_id(e));
    apb(1'h0, 12'h100, 32'h0);
    check(32'(rd[29:28]), 32'h2);
    apb(1'h1, DIR_OFS, 32'h5);
    apb(1'h1, AEOI_OFS, 32'h5);
    settle();
    check(32'({req_count[7:0], last_id}), 32'({8'h1, ph}));
    apb(1'h0, 12'h100, 32'h0);
    check(32'(rd[29:28]), 32'h0);
    $display("test hardware done");
    e = entry(1'h0, 1'h1, 5'h03, 10'h202, 10'h003);
    apb(1'h1, CTRL_OFS, 32'hA);
    apb(1'h1, 12'h104, e);
    settle();
    check(32'({virq, vfiq}), 32'h2);
    apb(1'h0, ACK_OFS, 32'h0);
    check(rd, ack_id(e));
    apb(1'h1, EOI_OFS, 32'h3);
    settle();
    check(32'({req_count[7:0], maint}), 32'h3);
    $display("test software done");
    e = entry(1'h1, 1'h1, 5'h01, ph ^ 10'h155, 10'h009);
    apb(1'h1, CTRL_OFS, 32'h203);
    apb(1'h1, 12'h108, e);
    settle();
    apb(1'h0, ACK_OFS, 32'h0);
    check(rd, ack_id(e));
    apb(1'h1, EOI_OFS, 32'h9);
    settle();
    check(req_count, 1);
    apb(1'h1, DIR_OFS, 32'h9);
    settle();
    check(32'({req_count[7:0], last_id}), 32'({8'h2, ph ^ 10'h155}));
    $display("test split done");
    // Running priority 4 against pending 2: the aliased point (6) hides the
    // gap, the plain point (2) does not
    apb(1'h1, ABPR_OFS, 32'h6);
    apb(1'h1, CTRL_OFS, 32'h2);
    e = entry(1'h0, 1'h1, 5'h04, 10'h000, 10'h00B);
    apb(1'h1, 12'h10C, e);
    apb(1'h0, ACK_OFS, 32'h0);
    check(rd, 32'h0000_000B);
    e = entry(1'h0, 1'h1, 5'h02, 10'h000, 10'h00C);
    apb(1'h1, 12'h108, e);
    settle();
    check(32'({virq, vfiq}), 32'h0);
    apb(1'h1, CTRL_OFS, 32'h12);
    settle();
    check(32'({virq, vfiq}), 32'h2);
    $display("test binary point done");
    test_done();
  end
endmodule // test_virtual_interrupt_list_entry
bind vle_entry_ctrl vle_entry_monitor #(.NUM_ENTRIES(NUM_ENTRIES)) mon_u (.clock(clock),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .virq(virq),
  .vfiq(vfiq), .dist_deact_valid(dist_deact_valid), .dist_deact_id(dist_deact_id),
  .eoi_maint_req(eoi_maint_req));
`default_nettype wire
